/* hw/mac_assist_pkg.sv */
// Shared constants, types and register map of the MAC assist block
package mac_assist_pkg;

  // ==========================================================
  // Register map: printed offsets are indices, byte = 4*index
  localparam logic [7:0] IDX_STATUS     = 8'h01;
  localparam logic [7:0] IDX_STATE_CTRL = 8'h02;
  localparam logic [7:0] IDX_EXT_CTRL_A = 8'h17;
  localparam logic [7:0] IDX_EXT_CTRL_B = 8'h2c;
  localparam int         ADDR_W         = 10;

  // ==========================================================
  // Field positions
  localparam int ACK_DELAY_BIT = 2;
  localparam int RES_ACCEPT_BIT = 4;
  localparam int RES_FILTER_BIT = 5;
  localparam int SLOTTED_BIT    = 0;
  localparam int CSMA_LSB       = 1;
  localparam int FRAME_LSB      = 4;
  localparam int RESULT_LSB     = 5;
  localparam logic [7:0] CTRL_A_MASK = 8'h34;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h38;

  // ==========================================================
  // Commands, transaction results and frame types
  localparam logic [4:0] CMD_TX_START   = 5'h02;
  localparam logic [4:0] CMD_OFF        = 5'h08;
  localparam logic [4:0] CMD_RX_ACK_ON  = 5'h16;
  localparam logic [4:0] CMD_TX_RETRY_ON = 5'h19;
  localparam logic [2:0] RES_SUCCESS    = 3'h0;
  localparam logic [2:0] RES_DATA_PEND  = 3'h1;
  localparam logic [2:0] RES_ACK_TRIG   = 3'h2;
  localparam logic [2:0] RES_CHAN_FAIL  = 3'h3;
  localparam logic [2:0] RES_NO_ACK     = 3'h5;
  localparam logic [2:0] RES_INVALID    = 3'h7;
  localparam logic [2:0] FT_DATA        = 3'h1;
  localparam logic [2:0] FT_COMMAND     = 3'h3;

  // ==========================================================
  // Timing
  localparam int CLK_NS         = 10;
  localparam int SYMBOL_US      = 16;
  localparam int ACK_STD_SYM    = 12;
  localparam int ACK_READY_SYM  = 3;
  localparam int ACK_WAIT_SYM   = 54;
  localparam int ACK_SHORT_US   = 32;
  localparam int ACK_LEAD_US    = 16;
  localparam int ACK_SHORT_CYC  = (ACK_SHORT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ACK_LEAD_CYC   = (ACK_LEAD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ACK_STD_DEF    =
    (ACK_STD_SYM * SYMBOL_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ACK_READY_DEF  =
    (ACK_READY_SYM * SYMBOL_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ACK_WAIT_DEF   =
    (ACK_WAIT_SYM * SYMBOL_US * 1000) / CLK_NS;
  localparam int CNT_W          = 17;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_OFF, ST_RX_LISTEN, ST_RX_BUSY, ST_ACK_DELAY, ST_ACK_HOLD,
    ST_ACK_LEAD, ST_TX_IDLE, ST_TX_CCA, ST_TX_SEND, ST_TX_ACKWAIT
  } state_t;

  typedef struct packed {
    logic       sfd;
    logic       frame_end;
    logic [2:0] frame_type;
    logic       fcs_ok;
    logic       addr_match;
    logic       ack_req;
  } rx_report_t;

  typedef struct packed {
    logic cca_done;
    logic cca_idle;
    logic tx_done;
    logic ack_req;
    logic ack_valid;
    logic ack_pending;
  } tx_report_t;

endpackage : mac_assist_pkg

/* hw/mac_assist.sv */
// Auto-acknowledge receive and auto-retry transmit assist with APB registers
`timescale 1ns/1ps
`default_nettype none

module mac_assist
  import mac_assist_pkg::*;
#(
  parameter int ACK_STD_CYC   = ACK_STD_DEF,
  parameter int ACK_READY_CYC = ACK_READY_DEF,
  parameter int ACK_WAIT_CYC  = ACK_WAIT_DEF
) (
  // Clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              NRST,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Receive and transmit reports from the radio
  input  wire rx_report_t        RX_REPORT,
  input  wire tx_report_t        TX_REPORT,
  // Host trigger pin
  input  wire logic              SLEEP_TX_TRIGGER_PIN,
  // Events and radio requests
  output logic                   FRAME_END_EVENT,
  output logic                   ADDRESS_MATCH_EVENT,
  output logic                   ACK_TX_START,
  output logic                   CCA_REQ,
  output logic                   FRAME_TX_START
);

  // ==========================================================
  // Elaboration checks
  if (ACK_STD_CYC < 1 || ACK_STD_CYC >= 2**CNT_W ||
      ACK_READY_CYC < 1 || ACK_READY_CYC >= 2**CNT_W ||
      ACK_WAIT_CYC < 1 || ACK_WAIT_CYC >= 2**CNT_W) begin : g_bad
    $error("mac_assist: timing count out of range");
  end

  // ==========================================================
  // State
  typedef struct packed {
    state_t           st;
    logic [7:0]       ctrl_a;
    logic [7:0]       ctrl_b;
    logic [2:0]       result;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] age;
    logic             trig_seen;
    logic [2:0]       csma;
    logic [3:0]       frames;
    logic [2:0]       sync;
    logic             trig_lvl;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             fe;
    logic             address_match_event;
    logic             ack_start;
    logic             cca_req;
    logic             tx_start;
  } core_t;

  localparam core_t CORE_RST = '{
    st: ST_OFF, ctrl_a: CTRL_A_RST, ctrl_b: CTRL_B_RST,
    result: RES_INVALID, default: '0};

  core_t r;
  core_t next_r;

  logic             acc;
  logic             done;
  logic [7:0]       idx;
  logic             reserved;
  logic             do_fe;
  logic             do_ami;
  logic             do_ack;
  logic             trig_edge;
  logic [CNT_W-1:0] delay_cyc;

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.fe = 1'b0;
    next_r.address_match_event = 1'b0;
    next_r.ack_start = 1'b0;
    next_r.cca_req = 1'b0;
    next_r.tx_start = 1'b0;
    next_r.age = r.age + 1'b1;
    idx = PADDR[ADDR_W-1:2];

    // Trigger pin synchroniser, counted once stages two and three agree
    next_r.sync = {r.sync[1:0], SLEEP_TX_TRIGGER_PIN};
    trig_edge = (r.sync[1] == r.sync[2]) && r.sync[2] && !r.trig_lvl;
    if (r.sync[1] == r.sync[2]) begin
      next_r.trig_lvl = r.sync[2];
    end

    // Frame classification
    reserved = RX_REPORT.frame_type[2];
    do_fe = 1'b0;
    do_ami = 1'b0;
    do_ack = 1'b0;
    if (reserved) begin
      if (r.ctrl_a[RES_ACCEPT_BIT]) begin
        if (r.ctrl_a[RES_FILTER_BIT]) begin
          do_ami = RX_REPORT.addr_match;
          do_fe = RX_REPORT.addr_match && RX_REPORT.fcs_ok;
          do_ack = do_fe && RX_REPORT.ack_req;
        end else begin
          do_fe = RX_REPORT.fcs_ok;
        end
      end
    end else begin
      do_ami = RX_REPORT.addr_match;
      do_fe = RX_REPORT.addr_match && RX_REPORT.fcs_ok;
      do_ack = do_fe && RX_REPORT.ack_req &&
               (RX_REPORT.frame_type == FT_DATA ||
                RX_REPORT.frame_type == FT_COMMAND);
    end
    delay_cyc = r.ctrl_a[ACK_DELAY_BIT] ?
                CNT_W'(ACK_SHORT_CYC) : CNT_W'(ACK_STD_CYC);

    // APB: answer one cycle into the access phase
    acc = PSEL && PENABLE;
    done = acc && r.pready;
    next_r.pready = acc && !r.pready;
    if (acc && !r.pready) begin
      next_r.pslverr = 1'b0;
      next_r.prdata = 32'h0;
      case (idx)
        IDX_STATUS:     next_r.prdata = {28'h0, r.st};
        IDX_STATE_CTRL: next_r.prdata = {24'h0, r.result, 5'h00};
        IDX_EXT_CTRL_A: next_r.prdata = {24'h0, r.ctrl_a};
        IDX_EXT_CTRL_B: next_r.prdata = {24'h0, r.ctrl_b};
        default:        next_r.pslverr = 1'b1;
      endcase
    end

    // Main sequencer
    case (r.st)
      ST_RX_LISTEN: begin
        if (RX_REPORT.sfd) begin
          next_r.st = ST_RX_BUSY;
        end
      end
      ST_RX_BUSY: begin
        if (RX_REPORT.frame_end) begin
          next_r.fe = do_fe;
          next_r.address_match_event = do_ami;
          next_r.cnt = CNT_W'(1);
          next_r.age = CNT_W'(1);
          next_r.trig_seen = 1'b0;
          if (!do_ack) begin
            next_r.st = ST_RX_LISTEN;
          end else if (r.ctrl_b[SLOTTED_BIT]) begin
            next_r.st = ST_ACK_HOLD;
            next_r.result = RES_ACK_TRIG;
          end else begin
            next_r.st = ST_ACK_DELAY;
          end
        end
      end
      ST_ACK_DELAY: begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == delay_cyc) begin
          next_r.ack_start = 1'b1;
          next_r.st = ST_RX_LISTEN;
        end
      end
      ST_ACK_HOLD: begin
        if (r.cnt < CNT_W'(ACK_READY_CYC)) begin
          next_r.cnt = r.cnt + 1'b1;
        end
        if (trig_edge) begin
          next_r.trig_seen = 1'b1;
        end
        if ((trig_edge || r.trig_seen) &&
            r.cnt >= CNT_W'(ACK_READY_CYC)) begin
          next_r.st = ST_ACK_LEAD;
          next_r.cnt = CNT_W'(1);
        end
      end
      ST_ACK_LEAD: begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == CNT_W'(ACK_LEAD_CYC)) begin
          next_r.ack_start = 1'b1;
          next_r.result = RES_SUCCESS;
          next_r.st = ST_RX_LISTEN;
        end
      end
      ST_TX_IDLE: begin
        if (done && PWRITE && idx == IDX_STATE_CTRL &&
            PWDATA[4:0] == CMD_TX_START) begin
          next_r.st = ST_TX_CCA;
          next_r.cca_req = 1'b1;
          next_r.csma = 3'h0;
          next_r.frames = 4'h0;
          next_r.result = RES_INVALID;
        end
      end
      ST_TX_CCA: begin
        if (TX_REPORT.cca_done) begin
          if (TX_REPORT.cca_idle) begin
            next_r.tx_start = 1'b1;
            next_r.st = ST_TX_SEND;
          end else if (r.csma == r.ctrl_b[CSMA_LSB +: 3]) begin
            next_r.result = RES_CHAN_FAIL;
            next_r.fe = 1'b1;
            next_r.st = ST_TX_IDLE;
          end else begin
            next_r.csma = r.csma + 1'b1;
            next_r.cca_req = 1'b1;
          end
        end
      end
      ST_TX_SEND: begin
        if (TX_REPORT.tx_done) begin
          next_r.cnt = CNT_W'(1);
          if (TX_REPORT.ack_req) begin
            next_r.st = ST_TX_ACKWAIT;
          end else begin
            next_r.result = RES_SUCCESS;
            next_r.fe = 1'b1;
            next_r.st = ST_TX_IDLE;
          end
        end
      end
      ST_TX_ACKWAIT: begin
        next_r.cnt = r.cnt + 1'b1;
        if (TX_REPORT.ack_valid) begin
          next_r.result = TX_REPORT.ack_pending ? RES_DATA_PEND : RES_SUCCESS;
          next_r.fe = 1'b1;
          next_r.st = ST_TX_IDLE;
        end else if (r.cnt == CNT_W'(ACK_WAIT_CYC)) begin
          if (r.frames == r.ctrl_b[FRAME_LSB +: 4]) begin
            next_r.result = RES_NO_ACK;
            next_r.fe = 1'b1;
            next_r.st = ST_TX_IDLE;
          end else begin
            next_r.frames = r.frames + 1'b1;
            next_r.csma = 3'h0;
            next_r.cca_req = 1'b1;
            next_r.st = ST_TX_CCA;
          end
        end
      end
      default: begin
      end
    endcase

    // Register writes take effect at the completing edge
    if (done && PWRITE) begin
      case (idx)
        IDX_EXT_CTRL_A: next_r.ctrl_a = PWDATA[7:0] & CTRL_A_MASK;
        IDX_EXT_CTRL_B: next_r.ctrl_b = PWDATA[7:0];
        IDX_STATE_CTRL: begin
          if (PWDATA[4:0] == CMD_RX_ACK_ON) begin
            next_r.st = ST_RX_LISTEN;
          end else if (PWDATA[4:0] == CMD_TX_RETRY_ON) begin
            next_r.st = ST_TX_IDLE;
          end else if (PWDATA[4:0] == CMD_OFF) begin
            next_r.st = ST_OFF;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      r <= CORE_RST;
    end else begin
      r <= next_r;
    end
  end

  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign FRAME_END_EVENT = r.fe;
  assign ADDRESS_MATCH_EVENT = r.address_match_event;
  assign ACK_TX_START = r.ack_start;
  assign CCA_REQ = r.cca_req;
  assign FRAME_TX_START = r.tx_start;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  logic rx_fin;
  assign rx_fin = r.st == ST_RX_BUSY && RX_REPORT.frame_end && reserved;

  property p_reserved_drop;
    rx_fin && !r.ctrl_a[RES_ACCEPT_BIT] |=>
      !FRAME_END_EVENT && !ADDRESS_MATCH_EVENT && r.st == ST_RX_LISTEN;
  endproperty
  a_reserved_drop: assert property (p_reserved_drop)
    else $error("reserved frame not dropped");

  property p_unfiltered;
    rx_fin && r.ctrl_a[RES_ACCEPT_BIT] && !r.ctrl_a[RES_FILTER_BIT] |=>
      FRAME_END_EVENT == $past(RX_REPORT.fcs_ok) && !ADDRESS_MATCH_EVENT
      && r.st == ST_RX_LISTEN;
  endproperty
  a_unfiltered: assert property (p_unfiltered)
    else $error("unfiltered reserved frame handled wrongly");

  property p_filtered_match;
    rx_fin && r.ctrl_a[RES_ACCEPT_BIT] && r.ctrl_a[RES_FILTER_BIT] |=>
      ADDRESS_MATCH_EVENT == $past(RX_REPORT.addr_match);
  endproperty
  a_filtered_match: assert property (p_filtered_match)
    else $error("address match event wrong");

  property p_filtered_end;
    rx_fin && r.ctrl_a[RES_ACCEPT_BIT] && r.ctrl_a[RES_FILTER_BIT] |=>
      FRAME_END_EVENT ==
        ($past(RX_REPORT.addr_match) && $past(RX_REPORT.fcs_ok));
  endproperty
  a_filtered_end: assert property (p_filtered_end)
    else $error("frame end event wrong for filtered frame");

  property p_filtered_ack;
    rx_fin && r.ctrl_a[RES_ACCEPT_BIT] && r.ctrl_a[RES_FILTER_BIT] |=>
      (r.st == ST_ACK_DELAY || r.st == ST_ACK_HOLD) ==
        ($past(RX_REPORT.ack_req) && FRAME_END_EVENT);
  endproperty
  a_filtered_ack: assert property (p_filtered_ack)
    else $error("ack decision wrong for filtered frame");

  property p_ack_std;
    ACK_TX_START && $past(r.st) == ST_ACK_DELAY &&
      !r.ctrl_a[ACK_DELAY_BIT] |-> r.age == CNT_W'(ACK_STD_CYC + 1);
  endproperty
  a_ack_std: assert property (p_ack_std)
    else $error("standard ack delay wrong");

  property p_ack_short;
    ACK_TX_START && $past(r.st) == ST_ACK_DELAY &&
      r.ctrl_a[ACK_DELAY_BIT] |-> r.age == CNT_W'(ACK_SHORT_CYC + 1);
  endproperty
  a_ack_short: assert property (p_ack_short)
    else $error("short ack delay wrong");

  property p_hold_code;
    r.st == ST_ACK_HOLD |-> r.result == RES_ACK_TRIG && !ACK_TX_START;
  endproperty
  a_hold_code: assert property (p_hold_code)
    else $error("pending code missing while holding ack");

  property p_busy_rx;
    r.st == ST_RX_LISTEN && RX_REPORT.sfd && !(PSEL && PENABLE) |=>
      r.st == ST_RX_BUSY;
  endproperty
  a_busy_rx: assert property (p_busy_rx)
    else $error("busy receive not entered");

  property p_tx_end;
    r.st == ST_TX_IDLE &&
      $past(r.st) inside {ST_TX_CCA, ST_TX_SEND, ST_TX_ACKWAIT} |->
      FRAME_END_EVENT;
  endproperty
  a_tx_end: assert property (p_tx_end)
    else $error("retry transaction ended without frame end");

endmodule : mac_assist

`default_nettype wire

/* test/radio_model.sv */
// Radio-side model answering channel assessment and transmit requests
`timescale 1ns/1ps
`default_nettype none

module radio_model
  import mac_assist_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Requests from the block
  input  wire logic       cca_req,
  input  wire logic       frame_tx_start,
  // Scenario controls
  input  wire logic       busy,
  input  wire logic       ack_on,
  input  wire logic       ack_give,
  input  wire logic       ack_pend,
  input  wire logic [7:0] lat,
  // Reports back
  output var tx_report_t  tx_report
);
  logic [7:0] cnt_c, cnt_t, cnt_a;
  logic       run_c, run_t, run_a;

  // ==========================================================
  // Answers lat+1 cycles after a request is sampled; idle levels carry stale inverses
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_report <= '0;
      {run_c, run_t, run_a} <= 3'h0;
      {cnt_c, cnt_t, cnt_a} <= 24'h0;
    end else begin
      tx_report.cca_done    <= 1'b0;
      tx_report.tx_done     <= 1'b0;
      tx_report.ack_valid   <= 1'b0;
      tx_report.ack_req     <= ack_on;
      tx_report.cca_idle    <= busy;
      tx_report.ack_pending <= !ack_pend;
      if (cca_req) begin
        run_c <= 1'b1;
        cnt_c <= lat;
      end else if (run_c && cnt_c == 8'h00) begin
        run_c <= 1'b0;
        tx_report.cca_done <= 1'b1;
        tx_report.cca_idle <= !busy;
      end else if (run_c) begin
        cnt_c <= cnt_c - 8'h01;
      end
      if (frame_tx_start) begin
        run_t <= 1'b1;
        cnt_t <= lat;
      end else if (run_t && cnt_t == 8'h00) begin
        run_t <= 1'b0;
        tx_report.tx_done <= 1'b1;
        run_a <= ack_on & ack_give;
        cnt_a <= lat;
      end else if (run_t) begin
        cnt_t <= cnt_t - 8'h01;
      end
      if (run_a && cnt_a == 8'h00) begin
        run_a <= 1'b0;
        tx_report.ack_valid   <= 1'b1;
        tx_report.ack_pending <= ack_pend;
      end else if (run_a) begin
        cnt_a <= cnt_a - 8'h01;
      end
    end
  end

endmodule : radio_model

`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the MAC assist block
`timescale 1ns/1ps
`default_nettype none

module testbench
  import mac_assist_pkg::*;
;
  localparam int STD = 40;
  localparam logic [9:0] A_STAT = {IDX_STATUS, 2'b00};
  localparam logic [9:0] A_CTRL = {IDX_STATE_CTRL, 2'b00};
  localparam logic [9:0] A_CA   = {IDX_EXT_CTRL_A, 2'b00};
  localparam logic [9:0] A_CB   = {IDX_EXT_CTRL_B, 2'b00};

  logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr;
  logic        trig, busy, ack_on, ack_give, ack_pend;
  logic        fe_ev, am_ev, ack_st, cca_req, tx_st;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  lat;
  rx_report_t  rx_rep;
  tx_report_t  tx_rep;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cca_n, txs_n;

  mac_assist #(.ACK_STD_CYC(STD), .ACK_READY_CYC(20), .ACK_WAIT_CYC(100))
  i_mac_assist (.CLK_SYS(clk_sys), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_REPORT(rx_rep), .TX_REPORT(tx_rep), .SLEEP_TX_TRIGGER_PIN(trig),
    .FRAME_END_EVENT(fe_ev), .ADDRESS_MATCH_EVENT(am_ev),
    .ACK_TX_START(ack_st), .CCA_REQ(cca_req), .FRAME_TX_START(tx_st));

  radio_model i_radio_model (.clk_sys(clk_sys), .nrst(nrst),
    .cca_req(cca_req), .frame_tx_start(tx_st), .busy(busy),
    .ack_on(ack_on), .ack_give(ack_give), .ack_pend(ack_pend),
    .lat(lat), .tx_report(tx_rep));

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (cca_req === 1'b1) cca_n++;
    if (tx_st === 1'b1) txs_n++;
  end

  // ==========================================================
  // Checks and bus access
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [31:0] exp,
                    input logic ee = 1'b0);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask : rd

  // ==========================================================
  // Receive frames and time the acknowledgement
  task automatic rx(input logic [2:0] ty, input logic f, m, q, efe, eam,
                    pk, input int dly);
    int k;
    int got;
    @(posedge clk_sys);
    rx_rep <= '{1'b1, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0};
    @(posedge clk_sys);
    rx_rep <= '0;
    if (pk) rd(A_STAT, 32'h2);
    @(posedge clk_sys);
    rx_rep <= '{1'b0, 1'b1, ty, f, m, q};
    got = 0;
    for (k = 1; k <= (dly == 0 ? STD + 10 : dly + 5); k++) begin
      @(posedge clk_sys);
      if (k == 1) rx_rep <= '0;
      #1;
      if (k == 1) begin
        chk(fe_ev, efe);
        chk(am_ev, eam);
      end
      if (ack_st === 1'b1 && got == 0) got = k;
    end
    chk(got, dly);
  endtask : rx

  task automatic rx_case(input logic acc, flt, input logic [2:0] ty,
                         input logic f, m, q, pk);
    logic res, fe, am, ak;
    res = ty[2];
    am  = res ? (acc & flt & m) : m;
    fe  = res ? (acc & f & (!flt | m)) : (m & f);
    ak  = fe & q & (res ? flt : (ty == FT_DATA || ty == FT_COMMAND));
    wr(A_CA, {26'h0, flt, acc, 4'h0});
    rx(ty, f, m, q, fe, am, pk, ak ? STD + 1 : 0);
  endtask : rx_case

  // ==========================================================
  // Retry transmit transaction
  task automatic tx_case(input logic b, on, give, pend,
                         input logic [7:0] lt, input logic [2:0] res,
                         input int nc, nt);
    int k;
    busy     <= b;
    ack_on   <= on;
    ack_give <= give;
    ack_pend <= pend;
    lat      <= lt;
    cca_n = 0;
    txs_n = 0;
    wr(A_CTRL, {27'h0, CMD_TX_START});
    if (lt > 8'd20) rd(A_CTRL, {24'h0, RES_INVALID, 5'h0});
    for (k = 0; k < 3000 && fe_ev !== 1'b1; k++) @(posedge clk_sys);
    chk(fe_ev, 1'b1);
    rd(A_CTRL, {24'h0, res, 5'h0});
    chk(cca_n, nc);
    chk(txs_n, nt);
  endtask : tx_case

  task automatic final_report();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    int k;
    clk_sys = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, trig} = 4'h0;
    {busy, ack_on, ack_give, ack_pend} = 4'h0;
    paddr = '0;
    pwdata = '0;
    rx_rep = '0;
    lat = 8'd30;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(A_CA, 32'h0);
    rd(A_CB, 32'h38);
    rd(A_CTRL, 32'he0);
    rd(A_STAT, 32'h0);
    rd(10'h3fc, 32'h0, 1'b1);
    wr(A_CTRL, {27'h0, CMD_RX_ACK_ON});
    rd(A_STAT, 32'h1);
    rx_case(0, 0, 3'h4, 1, 1, 1, 1);
    rx_case(1, 0, 3'h5, 1, 0, 1, 0);
    rx_case(1, 0, 3'h7, 0, 1, 1, 0);
    rx_case(1, 1, 3'h6, 1, 1, 1, 0);
    rx_case(1, 1, 3'h4, 1, 1, 0, 0);
    rx_case(1, 1, 3'h4, 1, 0, 1, 0);
    rx_case(1, 1, 3'h4, 0, 0, 1, 0);
    rx_case(0, 0, FT_DATA, 1, 1, 1, 0);
    rx_case(0, 0, FT_COMMAND, 1, 1, 0, 0);
    rx_case(0, 0, FT_DATA, 1, 0, 1, 0);
    wr(A_CB, 32'h39);
    rx(FT_DATA, 1, 1, 1, 1, 1, 0, 0);
    rd(A_CTRL, {24'h0, RES_ACK_TRIG, 5'h0});
    repeat (3200) @(posedge clk_sys);
    trig <= 1'b1;
    for (k = 1; k <= 1700; k++) begin
      @(posedge clk_sys);
      #1;
      if (ack_st === 1'b1) break;
    end
    @(posedge clk_sys);
    trig <= 1'b0;
    chk(k >= 1601 && k <= 1608, 1'b1);
    wr(A_CB, 32'h38);
    wr(A_CA, 32'h04);
    rx(FT_DATA, 1, 1, 1, 1, 1, 0, 3201);
    wr(A_CTRL, {27'h0, CMD_TX_RETRY_ON});
    rd(A_STAT, 32'h6);
    wr(A_CB, 32'h12);
    tx_case(0, 0, 0, 0, 8'd30, RES_SUCCESS, 1, 1);
    tx_case(0, 1, 1, 1, 8'd30, RES_DATA_PEND, 1, 1);
    tx_case(0, 1, 1, 0, 8'd2, RES_SUCCESS, 1, 1);
    tx_case(0, 1, 0, 0, 8'd30, RES_NO_ACK, 2, 2);
    tx_case(1, 0, 0, 0, 8'd2, RES_CHAN_FAIL, 2, 0);
    wr(A_CTRL, {27'h0, CMD_OFF});
    rd(A_STAT, 32'h0);
    final_report();
  end

endmodule : testbench

`default_nettype wire
